/* File: hw/dbg_bp_pkg.sv */
// Purpose: shared constants and carrier types for the breakpoint unit
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: control layout follows the classic enable/field arrangement
package dbg_bp_pkg;
   localparam int NUM_BP = 4;
   // register byte offsets
   localparam logic [7:0] OFF_ADDR0 = 8'h00;
   localparam logic [7:0] OFF_CONTROL = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_MODE = 8'h18;
   // control register fields
   localparam int CTL_TASK_ON_POS = 0;   // bit 2i
   localparam int CTL_GLOBAL_ON_POS = 1; // bit 2i+1
   localparam int CTL_PER_TASK_EXACT = 8;
   localparam int CTL_SYSTEM_EXACT = 9;
   localparam int CTL_GUARD = 13;
   localparam int CTL_USAGE_POS = 16;    // bits 16+4i .. 17+4i
   localparam int CTL_SIZE_POS = 18;     // bits 18+4i .. 19+4i
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTL_MASK = 32'hFFFF_23FF;
   // status register fields
   localparam int STS_GUARD_HIT = 13;
   localparam logic [31:0] STS_RESET = 32'h0000_0000;
   // usage and size codes
   localparam logic [1:0] USE_EXEC = 2'h0;
   localparam logic [1:0] USE_WRITE = 2'h1;
   localparam logic [1:0] USE_RW = 2'h3;
   localparam logic [1:0] SIZE_1 = 2'h0;
   localparam logic [1:0] SIZE_2 = 2'h1;
   localparam logic [1:0] SIZE_4 = 2'h3;
   // processor mode register: bit0 protected, bits 2:1 privilege
   localparam int MODE_PROT = 0;
   localparam int MODE_PL_POS = 1;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } fetch_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } data_access_type;

   typedef struct packed {
      logic fault;
      logic trap;
      logic [3:0] hits;
   } debug_event_type;
endpackage

/* File: hw/debug_breakpoint_unit.sv */
// Purpose: four-entry code and data breakpoint unit with control and status registers
// Assumes: processor logic presents fetch and data addresses synchronous to clk
// Notes: registers reached over apb; unmapped or refused access answers pslverr
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - two-bit size field per breakpoint
// - two-bit usage field per breakpoint
// - usage: exec, write only, read/write
// - size masks low address bits, aligned regions
// - data breakpoint compares stored linear address
// - exec match raises fault before instruction
// - access only real mode or level 0, except the mode register
// - guard bit blocks every register access except the mode register
// - data matching always exact
// - data trap after instruction, stall meanwhile
// - task switch clears per-task exact bit
// - system-wide exact bit survives task switch
// - exec breakpoints always reported precisely
// - active when global or local enable
// - status flag per debug event
// - all breakpoints disabled after reset
// - 32-bit linear address compared continuously
module debug_breakpoint_unit #(
   parameter int ADDR_W = 32
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor side
   input wire dbg_bp_pkg::fetch_type fetch,
   input wire dbg_bp_pkg::data_access_type data_acc,
   input wire logic instr_done,
   input wire logic task_switch,
   output logic hold_next_instr,
   output dbg_bp_pkg::debug_event_type dbg_event
);
   localparam int N = dbg_bp_pkg::NUM_BP;

   // register state
   logic [ADDR_W-1:0] bp_address_reg [N];
   logic [ADDR_W-1:0] next_bp_address_reg [N];
   logic [31:0] debug_control_reg;
   logic [31:0] next_debug_control_reg;
   logic [31:0] debug_status_reg;
   logic [31:0] next_debug_status_reg;
   logic [2:0] cpu_mode;
   logic [2:0] next_cpu_mode;
   logic [N-1:0] pend_data;
   logic [N-1:0] next_pend_data;
   logic [31:0] next_prdata;
   logic next_pslverr;
   dbg_bp_pkg::debug_event_type next_dbg_event;

   // per-breakpoint compare
   logic [N-1:0] bp_active;
   logic [N-1:0] exec_hit;
   logic [N-1:0] data_hit;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_bp
         logic [1:0] usage;
         logic [1:0] size;
         logic [ADDR_W-1:0] mask;
         assign usage = debug_control_reg[dbg_bp_pkg::CTL_USAGE_POS + 4*g +: 2];
         assign size = debug_control_reg[dbg_bp_pkg::CTL_SIZE_POS + 4*g +: 2];
         // low bits dropped per size so regions are always aligned
         always_comb begin
            unique case (size)
               dbg_bp_pkg::SIZE_2: mask = {{(ADDR_W-1){1'b1}}, 1'b0};
               dbg_bp_pkg::SIZE_4: mask = {{(ADDR_W-2){1'b1}}, 2'b00};
               default: mask = '1; // code 10 treated as one byte
            endcase
         end
         // either enable arms the entry
         assign bp_active[g] = debug_control_reg[2*g + dbg_bp_pkg::CTL_TASK_ON_POS]
            | debug_control_reg[2*g + dbg_bp_pkg::CTL_GLOBAL_ON_POS];
         assign exec_hit[g] = bp_active[g] && fetch.valid && usage == dbg_bp_pkg::USE_EXEC
            && ((fetch.addr & mask) == (bp_address_reg[g] & mask));
         // code 10 is left undefined and simply never matches
         assign data_hit[g] = bp_active[g] && data_acc.valid
            && (usage == dbg_bp_pkg::USE_RW
                || (usage == dbg_bp_pkg::USE_WRITE && data_acc.write))
            && ((data_acc.addr & mask) == (bp_address_reg[g] & mask));

         // undefined usage code must stay silent whatever else is armed
         a_usage_undef: assert property (@(posedge clk) disable iff (reset)
            usage == 2'h2 |-> !exec_hit[g] && !data_hit[g])
            else $error("usage code 10 matched");

         // a four-byte entry ignores the two low address bits
         a_size_align: assert property (@(posedge clk) disable iff (reset)
            bp_active[g] && fetch.valid && usage == dbg_bp_pkg::USE_EXEC
            && size == dbg_bp_pkg::SIZE_4
            && fetch.addr[ADDR_W-1:2] == bp_address_reg[g][ADDR_W-1:2] |-> exec_hit[g])
            else $error("four-byte region missed");

         // a two-byte entry ignores only bit zero
         a_size_half: assert property (@(posedge clk) disable iff (reset)
            bp_active[g] && data_acc.valid && usage == dbg_bp_pkg::USE_RW
            && size == dbg_bp_pkg::SIZE_2
            && data_acc.addr[ADDR_W-1:1] == bp_address_reg[g][ADDR_W-1:1] |-> data_hit[g])
            else $error("two-byte region missed");
      end
   endgenerate

   // access permission: real mode or level 0, and guard clear
   logic priv_ok;
   logic access_ok;
   logic apb_access;
   assign priv_ok = !cpu_mode[dbg_bp_pkg::MODE_PROT]
      || cpu_mode[dbg_bp_pkg::MODE_PL_POS +: 2] == 2'h0;
   assign access_ok = priv_ok && !debug_control_reg[dbg_bp_pkg::CTL_GUARD];
   assign apb_access = psel && penable && clk_en;
   assign pready = 1'b1; // zero wait state slave

   // next register values
   always_comb begin
      logic mode_hit;
      mode_hit = paddr == dbg_bp_pkg::OFF_MODE;
      for (int i = 0; i < N; i++) begin
         next_bp_address_reg[i] = bp_address_reg[i];
      end
      next_debug_control_reg = debug_control_reg;
      next_debug_status_reg = debug_status_reg;
      next_cpu_mode = cpu_mode;
      next_pend_data = pend_data;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      next_dbg_event = '0;
      // software access; the mode register is the processor's own and not guarded
      if (apb_access) begin
         if (mode_hit) begin
            if (pwrite) begin
               next_cpu_mode = pwdata[2:0];
            end
            next_prdata = {29'h0, cpu_mode};
         end else if (!access_ok) begin
            next_pslverr = 1'b1;
            next_prdata = 32'h0000_0000;
            if (debug_control_reg[dbg_bp_pkg::CTL_GUARD]) begin
               next_debug_status_reg[dbg_bp_pkg::STS_GUARD_HIT] = 1'b1;
            end
         end else if (paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0) begin
            if (pwrite) begin
               next_bp_address_reg[paddr[3:2]] = ADDR_W'(pwdata);
            end
            // address width may be a parameter, so size the read path on purpose
            next_prdata = 32'(bp_address_reg[paddr[3:2]]);
         end else if (paddr == dbg_bp_pkg::OFF_CONTROL) begin
            if (pwrite) begin
               next_debug_control_reg = pwdata & dbg_bp_pkg::CTL_MASK;
            end
            next_prdata = debug_control_reg;
         end else if (paddr == dbg_bp_pkg::OFF_STATUS) begin
            if (pwrite) begin
               next_debug_status_reg = pwdata;
            end
            next_prdata = debug_status_reg;
         end else begin
            next_pslverr = 1'b1;
            next_prdata = 32'h0000_0000;
         end
      end
      // per-task exact bit dropped on switch; hardware wins over a software write
      if (clk_en && task_switch) begin
         next_debug_control_reg[dbg_bp_pkg::CTL_PER_TASK_EXACT] = 1'b0;
      end
      // system-wide exact bit is left untouched here on purpose
      if (clk_en) begin
         // fault before the fetched instruction runs
         if (|exec_hit) begin
            next_dbg_event.fault = 1'b1;
            next_dbg_event.hits = exec_hit;
            next_debug_status_reg[N-1:0] = debug_status_reg[N-1:0] | exec_hit;
         end
         // data hits collect until the instruction retires; exact regardless of enables
         next_pend_data = pend_data | data_hit;
         if (instr_done && |(pend_data | data_hit)) begin
            next_dbg_event.trap = 1'b1;
            next_dbg_event.hits = pend_data | data_hit;
            next_debug_status_reg[N-1:0] = next_debug_status_reg[N-1:0]
               | pend_data | data_hit;
            next_pend_data = '0;
         end
      end
   end

   // stall the next instruction while a data trap is owed
   assign hold_next_instr = |pend_data | |data_hit;

   // register all state; reset leaves every breakpoint disabled
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < N; i++) begin
            bp_address_reg[i] <= '0;
         end
         debug_control_reg <= dbg_bp_pkg::CTL_RESET;
         debug_status_reg <= dbg_bp_pkg::STS_RESET;
         cpu_mode <= 3'h0;
         pend_data <= '0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         dbg_event <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < N; i++) begin
            bp_address_reg[i] <= next_bp_address_reg[i];
         end
         debug_control_reg <= next_debug_control_reg;
         debug_status_reg <= next_debug_status_reg;
         cpu_mode <= next_cpu_mode;
         pend_data <= next_pend_data;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         dbg_event <= next_dbg_event;
      end
   end

   // a fault pulse follows an enabled execute hit by exactly one cycle
   a_exec_fault_timing: assert property (@(posedge clk) disable iff (reset)
      clk_en && |exec_hit |=> dbg_event.fault) else $error("execute hit gave no fault");
   // and never appears without one
   a_fault_needs_hit: assert property (@(posedge clk) disable iff (reset)
      clk_en && !(|exec_hit) |=> !dbg_event.fault) else $error("fault with no execute hit");
   a_no_fault_reset: assert property (@(posedge clk) disable iff (reset)
      !(|bp_active) |=> !dbg_event.fault) else $error("fault with no breakpoint armed");
   // an entry with both enables clear can not match at all
   a_no_hit_idle: assert property (@(posedge clk) disable iff (reset)
      !(|bp_active) |-> !(|exec_hit) && !(|data_hit))
      else $error("disarmed breakpoint matched");

   // task switch handling of the two exact-match bits
   a_task_clear: assert property (@(posedge clk) disable iff (reset)
      clk_en && task_switch |=> !debug_control_reg[dbg_bp_pkg::CTL_PER_TASK_EXACT])
      else $error("per-task exact bit survived switch");
   a_sys_exact_keep: assert property (@(posedge clk) disable iff (reset)
      clk_en && task_switch && !apb_access
      |=> $stable(debug_control_reg[dbg_bp_pkg::CTL_SYSTEM_EXACT]))
      else $error("system exact bit changed on switch");

   // refused accesses: error answer, no write, zero read data
   a_guard_block: assert property (@(posedge clk) disable iff (reset)
      apb_access && debug_control_reg[dbg_bp_pkg::CTL_GUARD] && paddr != dbg_bp_pkg::OFF_MODE
      |=> pslverr && $stable(debug_control_reg[31:10]))
      else $error("guarded access not refused");
   a_priv_block: assert property (@(posedge clk) disable iff (reset)
      apb_access && !priv_ok && paddr != dbg_bp_pkg::OFF_MODE |=> pslverr)
      else $error("unprivileged access not refused");
   a_refused_zero: assert property (@(posedge clk) disable iff (reset)
      apb_access && !access_ok && paddr != dbg_bp_pkg::OFF_MODE |=> prdata == 32'h0000_0000)
      else $error("refused access returned data");
   // the handler must be able to tell a guard refusal happened
   a_guard_status: assert property (@(posedge clk) disable iff (reset)
      apb_access && debug_control_reg[dbg_bp_pkg::CTL_GUARD] && paddr != dbg_bp_pkg::OFF_MODE
      |=> debug_status_reg[dbg_bp_pkg::STS_GUARD_HIT])
      else $error("guard refusal not flagged");

   // data traps: held until retirement, then one pulse carrying every owed hit
   a_data_trap_wait: assert property (@(posedge clk) disable iff (reset)
      clk_en && |data_hit && !instr_done |=> hold_next_instr && !dbg_event.trap)
      else $error("data trap not held to completion");
   a_data_trap_pulse: assert property (@(posedge clk) disable iff (reset)
      clk_en && instr_done && (|pend_data || |data_hit) |=> dbg_event.trap)
      else $error("owed data trap not raised");
   a_trap_hits: assert property (@(posedge clk) disable iff (reset)
      clk_en && instr_done && |pend_data
      |=> (dbg_event.hits & $past(pend_data)) == $past(pend_data))
      else $error("trap lost a pending hit");
   a_pend_clear: assert property (@(posedge clk) disable iff (reset)
      clk_en && instr_done |=> pend_data == '0)
      else $error("pending hits survived retirement");

   // every reported event leaves its flag in the status register
   a_status_flag: assert property (@(posedge clk) disable iff (reset)
      dbg_event.fault || dbg_event.trap
      |-> (debug_status_reg[N-1:0] & dbg_event.hits) == dbg_event.hits)
      else $error("status flag missing for event");
endmodule

/* File: test/proc_model.sv */
// Purpose: processor-side stand-in driving fetch, operand and completion strobes
// Assumes: one instruction at a time, all strobes synchronous to clk
// Notes: released address lines show the inverse of the last value
`timescale 1ns/1ps
module proc_model (
   // clock and stall
   input wire logic clk,
   input wire logic hold_next_instr,
   // processor events
   output dbg_bp_pkg::fetch_type fetch,
   output dbg_bp_pkg::data_access_type data_acc,
   output logic instr_done,
   output logic task_switch
);
   // quiet at time zero
   initial begin
      fetch = '0;
      data_acc = '0;
      instr_done = 1'b0;
      task_switch = 1'b0;
   end
   // fetch, one operand, completion; a stalled core never starts the next one
   task run(input logic [31:0] ia, input logic dw, input logic [31:0] da);
      @(posedge clk);
      while (hold_next_instr === 1'b1) @(posedge clk);
      fetch <= {1'b1, ia};
      @(posedge clk);
      fetch <= {1'b0, ~ia};
      data_acc <= {1'b1, dw, da};
      @(posedge clk);
      data_acc <= {1'b0, dw, ~da};
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
   endtask
   // task switch is a one-cycle strobe
   task switch_task();
      @(posedge clk);
      task_switch <= 1'b1;
      @(posedge clk);
      task_switch <= 1'b0;
   endtask
endmodule

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the breakpoint unit against a queue-free model
// Assumes: zero-wait apb, read data valid the cycle after the access edge
// Notes: event pulses are counted over a window, so a stuck pulse shows up
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, ctl, m_ctl, ia, da;
   logic [31:0] m_addr [4];
   logic pready, pslverr, er, hold_next_instr, instr_done, task_switch, dw, hd;
   logic [3:0] hv, eh, dh;
   dbg_bp_pkg::fetch_type fetch;
   dbg_bp_pkg::data_access_type data_acc;
   dbg_bp_pkg::debug_event_type dbg_event;
   int n_fail = 0, n_tests = 0, cyc = 0, nf, nt;
   always #50 clk = ~clk;
   debug_breakpoint_unit dut_u (.clk(clk), .reset(reset), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fetch(fetch), .data_acc(data_acc),
      .instr_done(instr_done), .task_switch(task_switch),
      .hold_next_instr(hold_next_instr), .dbg_event(dbg_event));
   proc_model proc_u (.clk(clk), .hold_next_instr(hold_next_instr), .fetch(fetch),
      .data_acc(data_acc), .instr_done(instr_done), .task_switch(task_switch));
   // pulse counters; a one-cycle pulse counts exactly once
   always @(negedge clk) begin
      if (dbg_event.fault === 1'b1) nf++;
      if (dbg_event.trap === 1'b1) nt++;
      if (dbg_event.fault === 1'b1 || dbg_event.trap === 1'b1) hv = hv | dbg_event.hits;
      if (hold_next_instr === 1'b1) hd = 1'b1;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   task final_report();
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task do_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
   endtask
   // one apb transfer; result sampled once the registered answer has landed
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
      rd = prdata;
      er = pslverr;
   endtask
   // reference compare: k 0 exec, 1 write, 2 read
   function automatic logic [3:0] hits(input logic [1:0] k, input logic [31:0] a);
      logic [3:0] h;
      logic [31:0] m;
      logic [1:0] u, s;
      h = '0;
      for (int i = 0; i < 4; i++) begin
         u = m_ctl[16+4*i +: 2];
         s = m_ctl[18+4*i +: 2];
         m = (s == 2'h3) ? 32'hFFFF_FFFC : (s == 2'h1) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
         if ((m_ctl[2*i] || m_ctl[2*i+1]) && ((a & m) == (m_addr[i] & m)) &&
            ((k == 2'h0 && u == 2'h0) || (k == 2'h1 && u[0]) || (k == 2'h2 && u == 2'h3)))
            h[i] = 1'b1;
      end
      return h;
   endfunction
   initial begin
      void'($urandom(28));
      do_reset();
      apb(1'b0, dbg_bp_pkg::OFF_CONTROL, 32'h0);
      chk("ctl_reset", rd, 32'h0);
      apb(1'b0, dbg_bp_pkg::OFF_STATUS, 32'h0);
      chk("sts_reset", rd, 32'h0);
      nf = 0;
      proc_u.run(32'h0, 1'b1, 32'h0);
      repeat (3) @(posedge clk);
      chk("fault_after_reset", nf, 0);
      for (int it = 0; it < 40; it++) begin
         ctl = $urandom & 32'hFFFF_03FF; // exact bits random
         for (int i = 0; i < 4; i++) begin
            if (ctl[16+4*i +: 2] == 2'h2) ctl[16+4*i +: 2] = 2'h3;
            if (ctl[16+4*i +: 2] == 2'h0) ctl[18+4*i +: 2] = 2'h0;
            m_addr[i] = $urandom;
            apb(1'b1, dbg_bp_pkg::OFF_ADDR0 + 8'(4 * i), m_addr[i]);
         end
         m_ctl = ctl;
         apb(1'b1, dbg_bp_pkg::OFF_CONTROL, ctl);
         apb(1'b0, dbg_bp_pkg::OFF_CONTROL, 32'h0);
         chk("ctl_read", rd, ctl);
         apb(1'b1, dbg_bp_pkg::OFF_STATUS, 32'h0);
         ia = m_addr[$urandom % 4] ^ ($urandom & 3);
         da = m_addr[$urandom % 4] ^ ($urandom & 7);
         dw = 1'($urandom);
         eh = hits(2'h0, ia);
         dh = hits(dw ? 2'h1 : 2'h2, da);
         nf = 0;
         nt = 0;
         hv = '0;
         hd = 1'b0;
         proc_u.run(ia, dw, da);
         repeat (3) @(posedge clk);
         chk("fault", nf, (eh != 0));
         chk("trap", nt, (dh != 0));
         chk("hits", hv, eh | dh);
         chk("stall", hd, (dh != 0));
         apb(1'b0, dbg_bp_pkg::OFF_STATUS, 32'h0);
         chk("status", rd[3:0], eh | dh);
      end
      apb(1'b1, dbg_bp_pkg::OFF_CONTROL, 32'h0000_0300);
      proc_u.switch_task();
      apb(1'b0, dbg_bp_pkg::OFF_CONTROL, 32'h0);
      chk("ctl_switch", rd, 32'h0000_0200);
      apb(1'b1, dbg_bp_pkg::OFF_MODE, 32'h0000_0007);
      apb(1'b1, dbg_bp_pkg::OFF_CONTROL, 32'h0000_0001);
      chk("priv_wr_err", er, 1'b1);
      apb(1'b1, dbg_bp_pkg::OFF_MODE, 32'h0000_0001);
      apb(1'b0, dbg_bp_pkg::OFF_CONTROL, 32'h0);
      chk("priv_no_write", {er, rd}, {1'b0, 32'h0000_0200});
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped_err", er, 1'b1);
      apb(1'b1, dbg_bp_pkg::OFF_CONTROL, 32'h0000_2000);
      apb(1'b0, dbg_bp_pkg::OFF_STATUS, 32'h0);
      chk("guard_err", {er, rd}, {1'b1, 32'h0});
      do_reset();
      apb(1'b0, dbg_bp_pkg::OFF_CONTROL, 32'h0);
      chk("reset_again", {er, rd}, {1'b0, 32'h0});
      final_report();
   end
endmodule
